// *** rtl/sdasr_pkg.sv ***
// Purpose : shared constants for the sigma-delta converter serial readout
// Assumes : one 24-bit result per decimation period of the crystal clock
// Notes   : counts are in crystal periods unless the name says otherwise

package sdasr_pkg;

  // ----------------------------------------------------------------
  // result word
  // ----------------------------------------------------------------
  localparam int          WORD_BITS    = 24;
  localparam int          BIT_CNT_W    = 5;
  localparam logic [4:0]  LAST_BIT     = 5'h17;        // 24th rising edge
  localparam logic [23:0] WORD_RESET   = 24'h00_0000;
  localparam int          SIGN_POS     = 23;           // msb of filter word

  // ----------------------------------------------------------------
  // crystal and decimation timing
  // ----------------------------------------------------------------
  localparam int          CRYSTAL_HZ   = 32768;
  localparam int          DECIM_A      = 69;
  localparam int          DECIM_B      = 8;
  localparam int          DECIM_C      = 3;
  localparam int          DECIM_CYCLES = DECIM_A * DECIM_B * DECIM_C;
  localparam int          DIV_W        = 11;
  localparam int          SETTLE_PERIODS = 2;          // first result after two periods
  localparam int          WARN_MARGIN  = 2;            // crystal periods before update
  localparam logic [10:0] DIV_LAST     = 11'(DECIM_CYCLES - 1);
  localparam logic [10:0] DIV_WARN     = 11'(DECIM_CYCLES - 1 - WARN_MARGIN);
  localparam logic [10:0] DIV_RESET    = 11'h000;

  // ----------------------------------------------------------------
  // pll lock wait and mode pin
  // ----------------------------------------------------------------
  localparam int          PLL_LOCK_CYCLES = 64;
  localparam int          LOCK_W       = 12;
  localparam logic [11:0] LOCK_RESET   = 12'h000;
  localparam logic        MODE_MASTER  = 1'b0;

  // ----------------------------------------------------------------
  // readout state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_CONVERT = 2'b01,
    ST_READY   = 2'b10,
    ST_SHIFT   = 2'b11
  } sdasr_state_e;

endpackage : sdasr_pkg

// *** rtl/sdasr_crystal_clock_timer.sv ***
// Purpose : crystal-domain conversion timer, pll lock wait and result capture
// Assumes : crystal_clock_i runs free; cs_n_i is an unsynchronised pin
// Notes   : result_o is held a whole decimation period after each done toggle

`timescale 1ns/1ps
`default_nettype none

module sdasr_crystal_timer
#(
  parameter int LOCK_CYCLES = sdasr_pkg::PLL_LOCK_CYCLES
)
(
  // crystal domain
  input  wire logic                       crystal_clock_i,
  input  wire logic                       resetn_i,
  // chip select pin
  input  wire logic                       cs_n_i,
  // decimation filter word, two's complement
  input  wire logic [sdasr_pkg::WORD_BITS-1:0] filter_word_i,
  // towards the system domain
  output logic      [sdasr_pkg::WORD_BITS-1:0] result_o,
  output logic                            done_toggle_o,
  output logic                            warn_toggle_o
);
  import sdasr_pkg::*;

  // the twelve-bit lock counter bounds the lock wait
  if (LOCK_CYCLES < 1 || LOCK_CYCLES > 4095)
  begin : g_bad_lock
    $error("LOCK_CYCLES out of range");
  end

  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES - 1);

  typedef struct packed {
    logic                 cs_meta;
    logic                 cs_sync;
    logic [LOCK_W-1:0]    lock_cnt;
    logic                 locked;
    logic [DIV_W-1:0]     div_cnt;
    logic                 settling;
    logic [WORD_BITS-1:0] word;
    logic                 done_tgl;
    logic                 warn_tgl;
  } sdasr_xt_s;

  sdasr_xt_s r;
  sdasr_xt_s next_r;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // standby clears the pll and timer; results only after lock
  always_comb
  begin
    next_r         = r;
    next_r.cs_meta = cs_n_i;
    next_r.cs_sync = r.cs_meta;
    if (r.cs_sync)
    begin
      // deselect aborts the conversion and drops the held word
      next_r.lock_cnt = LOCK_RESET;
      next_r.locked   = 1'b0;
      next_r.div_cnt  = DIV_RESET;
      next_r.settling = 1'b1;
      next_r.word     = WORD_RESET;
    end
    else if (!r.locked)
    begin
      // wait for the pll before the first conversion starts
      next_r.lock_cnt = r.lock_cnt + 1'b1;
      if (r.lock_cnt == LOCK_LAST)
        next_r.locked = 1'b1;
    end
    else
    begin
      // free running back to back conversions
      next_r.div_cnt = r.div_cnt + 1'b1;
      if (r.div_cnt == DIV_WARN)
        next_r.warn_tgl = ~r.warn_tgl;
      if (r.div_cnt == DIV_LAST)
      begin
        // period of 69*8*3 crystal cycles sets rate and mains notches
        next_r.div_cnt = DIV_RESET;
        if (r.settling)
          next_r.settling = 1'b0;
        else
        begin
          // offset binary: flip the sign of the filter word
          next_r.word     = {~filter_word_i[SIGN_POS], filter_word_i[SIGN_POS-1:0]};
          next_r.done_tgl = ~r.done_tgl;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge crystal_clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      r <= '{cs_meta: 1'b1, cs_sync: 1'b1, lock_cnt: LOCK_RESET, locked: 1'b0,
             div_cnt: DIV_RESET, settling: 1'b1, word: WORD_RESET,
             done_tgl: 1'b0, warn_tgl: 1'b0};
    else
      r <= next_r;
  end

  assign result_o      = r.word;
  assign done_toggle_o = r.done_tgl;
  assign warn_toggle_o = r.warn_tgl;

endmodule : sdasr_crystal_timer

`default_nettype wire

// *** rtl/sdasr_readout.sv ***
// Purpose : serial readout of a 24-bit sigma-delta converter, master or slave
// Assumes : clk_i well above the crystal and serial clock rates
// Notes   : crystal domain timer crosses by toggles with a held result word
//
// What this block does
// - chip select low: power up, wait for pll lock, then start converting.
// - chip select high: abort, standby, release both pins, drop held result.
// - with chip select low, conversions run back to back until deselect.
// - data-out/ready high during conversion, pulled low when a result is ready.
// - unread result: ready line returns high before the next update.
// - after the word is read the ready line goes high until next result.
// - master mode: ready low at least half a serial clock before pulses.
// - bits change on serial clock fall; receiver samples on the rise.
// - mode pin low selects master, high selects slave.
// - master drives the serial clock; slave takes it from the host.
// - one result per 69*8*3 crystal periods, about 19.79 per second.
// - first settled result only after two output periods.
// - decimation period places notches at both mains frequencies.
// - master serial clock period equals one crystal period.
// - master emits 24 pulses per result, then idles the clock high.
// - result in offset binary: zeros, top bit only, ones.

`timescale 1ns/1ps
`default_nettype none

module sdasr_readout
#(
  parameter int LOCK_CYCLES = sdasr_pkg::PLL_LOCK_CYCLES
)
(
  // system clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  // crystal clock, second domain
  input  wire logic                       crystal_clock_i,
  // configuration and select pins
  input  wire logic                       cs_n_i,
  input  wire logic                       mode_i,
  // serial clock pin, two-way
  input  wire logic                       sclk_i,
  output logic                            sclk_o,
  output logic                            sclk_oe_o,
  // data-out / ready pin
  output logic                            dout_rdy_o,
  output logic                            dout_rdy_oe_o,
  // decimation filter word, crystal domain
  input  wire logic [sdasr_pkg::WORD_BITS-1:0] filter_word_i
);
  import sdasr_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // shift path, bit counter and last-bit constant are sized for 24 bits
  if (WORD_BITS != 24)
  begin : g_bad_width
    $error("readout logic serves only a 24-bit word");
  end
  // the timer's twelve-bit lock counter bounds the lock wait
  if (LOCK_CYCLES < 1 || LOCK_CYCLES > 4095)
  begin : g_bad_lock
    $error("LOCK_CYCLES out of range for the lock counter");
  end

  // ----------------------------------------------------------------
  // crystal domain timer
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] xt_result;
  logic                 xt_done_tgl;
  logic                 xt_warn_tgl;

  sdasr_crystal_timer
  #(
    .LOCK_CYCLES (LOCK_CYCLES)
  )
  u_timer
  (
    .crystal_clock_i (crystal_clock_i),
    .resetn_i        (resetn_i),
    .cs_n_i          (cs_n_i),
    .filter_word_i   (filter_word_i),
    .result_o        (xt_result),
    .done_toggle_o   (xt_done_tgl),
    .warn_toggle_o   (xt_warn_tgl)
  );

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  // every synchroniser stage lives here; meta stages feed only sync stages
  typedef struct packed {
    logic                 cs_meta;
    logic                 cs_sync;
    logic                 mode_meta;
    logic                 mode_sync;
    logic                 sck_meta;
    logic                 sck_sync;
    logic                 sck_prev;
    logic                 xt_meta;
    logic                 xt_sync;
    logic                 xt_prev;
    logic                 dn_meta;
    logic                 dn_sync;
    logic                 dn_prev;
    logic                 wn_meta;
    logic                 wn_sync;
    logic                 wn_prev;
    sdasr_state_e         st;
    logic [WORD_BITS-1:0] shreg;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic                 dout;
    logic                 sclk;
    logic                 sclk_en;
  } sdasr_rd_s;

  sdasr_rd_s r;
  sdasr_rd_s next_r;

  // ----------------------------------------------------------------
  // edge helpers
  // ----------------------------------------------------------------
  // level pair to a one-cycle strobe; used for crystal and host clocks
  function automatic logic rise_of(input logic now, input logic prev);
    rise_of = now & ~prev;
  endfunction : rise_of

  function automatic logic fall_of(input logic now, input logic prev);
    fall_of = ~now & prev;
  endfunction : fall_of

  // drop the bit just presented; zeros fill in behind it
  function automatic logic [WORD_BITS-1:0] shift_left(input logic [WORD_BITS-1:0] w);
    shift_left = {w[WORD_BITS-2:0], 1'b0};
  endfunction : shift_left

  logic master;
  logic done_ev;
  logic warn_ev;
  logic xt_rise;
  logic xt_fall;
  logic bit_fall;
  logic bit_rise;

  // events seen from synchronised stages only
  // every strobe here lasts exactly one clk_i cycle
  always_comb
  begin
    master   = (r.mode_sync == MODE_MASTER);
    done_ev  = r.dn_sync ^ r.dn_prev;
    warn_ev  = r.wn_sync ^ r.wn_prev;
    xt_rise  = rise_of(r.xt_sync, r.xt_prev);
    xt_fall  = fall_of(r.xt_sync, r.xt_prev);
    // master shifts on its own crystal-derived clock, slave on the host's
    bit_fall = master ? (r.sclk_en & xt_fall) : fall_of(r.sck_sync, r.sck_prev);
    bit_rise = master ? (r.sclk_en & xt_rise) : rise_of(r.sck_sync, r.sck_prev);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    // two-stage synchronisers for pins and crossing toggles
    next_r.cs_meta   = cs_n_i;
    next_r.cs_sync   = r.cs_meta;
    next_r.mode_meta = mode_i;
    next_r.mode_sync = r.mode_meta;
    next_r.sck_meta  = sclk_i;
    next_r.sck_sync  = r.sck_meta;
    next_r.sck_prev  = r.sck_sync;
    next_r.xt_meta   = crystal_clock_i;
    next_r.xt_sync   = r.xt_meta;
    next_r.xt_prev   = r.xt_sync;
    next_r.dn_meta   = xt_done_tgl;
    next_r.dn_sync   = r.dn_meta;
    next_r.dn_prev   = r.dn_sync;
    next_r.wn_meta   = xt_warn_tgl;
    next_r.wn_sync   = r.wn_meta;
    next_r.wn_prev   = r.wn_sync;

    if (r.cs_sync)
    begin
      // deselected: standby, pins released, held word lost
      next_r.st      = ST_STANDBY;
      next_r.shreg   = WORD_RESET;
      next_r.bit_cnt = '0;
      next_r.dout    = 1'b1;
      next_r.sclk_en = 1'b0;
    end
    else
    begin
      unique case (r.st)
        ST_STANDBY:
        begin
          // selected: timer waits for lock, line shows busy meanwhile
          next_r.st   = ST_CONVERT;
          next_r.dout = 1'b1;
        end
        ST_CONVERT:
        begin
          // serial edges are ignored until a result is pending
          next_r.dout = 1'b1;
          if (done_ev)
          begin
            // held word is stable for a whole period after the toggle
            next_r.shreg   = xt_result;
            next_r.bit_cnt = '0;
            next_r.dout    = 1'b0;
            next_r.st      = ST_READY;
          end
        end
        ST_READY:
        begin
          if (warn_ev)
          begin
            // unread result: back to busy before the update lands
            // the pending word is simply replaced by the next one
            next_r.dout = 1'b1;
            next_r.st   = ST_CONVERT;
          end
          else if (master && xt_rise)
          begin
            // first fall comes half a crystal period later at the earliest
            next_r.sclk_en = 1'b1;
            next_r.st      = ST_SHIFT;
          end
          else if (!master && bit_fall)
          begin
            next_r.dout  = r.shreg[WORD_BITS-1];
            next_r.shreg = shift_left(r.shreg);
            next_r.st    = ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (warn_ev)
          begin
            // an unfinished read must not straddle the update
            next_r.dout    = 1'b1;
            next_r.sclk_en = 1'b0;
            next_r.st      = ST_CONVERT;
          end
          else if (bit_fall)
          begin
            // data changes on the fall, msb first
            next_r.dout  = r.shreg[WORD_BITS-1];
            next_r.shreg = shift_left(r.shreg);
          end
          else if (bit_rise)
          begin
            next_r.bit_cnt = r.bit_cnt + 1'b1;
            if (r.bit_cnt == LAST_BIT)
            begin
              // 24 pulses done: clock idles high, line busy until next result
              next_r.sclk_en = 1'b0;
              // last bit stands past its rise; convert raises the line a cycle later
              next_r.bit_cnt = '0;
              next_r.st      = ST_CONVERT;
            end
          end
        end
      endcase
    end

    // master clock follows the crystal, one crystal period per pulse
    // edges lag the crystal by the synchroniser; the period is kept
    next_r.sclk = next_r.sclk_en ? r.xt_sync : 1'b1;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // async clear gives the deselected picture: pins released, line high
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      r <= '{cs_meta: 1'b1, cs_sync: 1'b1, mode_meta: 1'b0, mode_sync: 1'b0,
             sck_meta: 1'b1, sck_sync: 1'b1, sck_prev: 1'b1,
             xt_meta: 1'b0, xt_sync: 1'b0, xt_prev: 1'b0,
             dn_meta: 1'b0, dn_sync: 1'b0, dn_prev: 1'b0,
             wn_meta: 1'b0, wn_sync: 1'b0, wn_prev: 1'b0,
             st: ST_STANDBY, shreg: WORD_RESET, bit_cnt: '0,
             dout: 1'b1, sclk: 1'b1, sclk_en: 1'b0};
    else
      r <= next_r;
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // enables come from registered select and mode; high-z while deselected
  // the pad ring resolves the enables; board pull-ups set the idle levels
  assign sclk_o        = r.sclk;
  assign sclk_oe_o     = ~r.cs_sync & master;
  assign dout_rdy_o    = r.dout;
  assign dout_rdy_oe_o = ~r.cs_sync;

endmodule : sdasr_readout

`default_nettype wire

// *** test/sdasr_readout_chk.sv ***
// Purpose : pin assertions for the converter serial readout
// Assumes : clk_i far faster than the crystal clock
// Notes   : burst counters follow the master clock only
`timescale 1ns/1ps
`default_nettype none
module sdasr_readout_chk
(
  // clock and reset
  input wire logic                              clk_i,
  input wire logic                              resetn_i,
  // watched pins
  input wire logic                              crystal_clock_i,
  input wire logic                              cs_n_i,
  input wire logic                              mode_i,
  input wire logic                              sclk_i,
  input wire logic                              sclk_o,
  input wire logic                              sclk_oe_o,
  input wire logic                              dout_rdy_o,
  input wire logic                              dout_rdy_oe_o,
  input wire logic [sdasr_pkg::WORD_BITS-1:0]   filter_word_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [3:0] hi_q;
  logic [4:0] pulses;
  // a long high spell marks a new burst; in-burst highs last 3..4 cycles
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      hi_q   <= 4'h0;
      pulses <= 5'h00;
    end
    else
    begin
      hi_q <= !sclk_o ? 4'h0 : ((hi_q == 4'hf) ? hi_q : hi_q + 4'h1);
      if (!sclk_oe_o) pulses <= 5'h00;
      else if ($fell(sclk_o)) pulses <= (hi_q >= 4'h8) ? 5'h01 : pulses + 5'h01;
    end
  a_deselect_release: assert property (cs_n_i [*6] |-> !dout_rdy_oe_o && !sclk_oe_o)
    else $error("pins still driven while deselected");
  a_select_drive: assert property (!cs_n_i [*6] |-> dout_rdy_oe_o)
    else $error("ready line not driven while selected");
  a_master_clk_out: assert property ((!cs_n_i && !mode_i) [*6] |-> sclk_oe_o)
    else $error("master does not drive serial clock");
  a_slave_clk_in: assert property (mode_i [*6] |-> !sclk_oe_o && sclk_o)
    else $error("slave drives serial clock");
  a_half_period: assert property ($fell(sclk_o) |-> ##1 !sclk_o ##1 !sclk_o ##[1:2] sclk_o)
    else $error("serial clock low phase not half a crystal period");
  a_ready_lead: assert property ($fell(sclk_o) && hi_q >= 4'h8 |-> !$past(dout_rdy_o, 1) && !$past(dout_rdy_o, 3))
    else $error("ready low too short before first pulse");
  a_pulse_count: assert property ($fell(sclk_o) |-> (hi_q >= 4'h8) ? (pulses == 5'h00 || pulses == 5'h18) : (pulses < 5'h18))
    else $error("burst is not 24 pulses");
  a_busy_after: assert property ($rose(sclk_o) && pulses == 5'h18 |-> ##[1:6] dout_rdy_o)
    else $error("ready line not high after last bit");
  a_data_stable: assert property ($rose(sclk_o) && sclk_oe_o |-> $stable(dout_rdy_o))
    else $error("data changed at rising serial edge");
  a_burst_len: assert property (sclk_oe_o && sclk_o && hi_q == 4'h7 |-> pulses == 5'h00 || pulses == 5'h18)
    else $error("serial clock idles after a burst that was not 24 pulses");
endmodule : sdasr_readout_chk
bind sdasr_readout sdasr_readout_chk chk (.clk_i(clk_i), .resetn_i(resetn_i), .crystal_clock_i(crystal_clock_i),
  .cs_n_i(cs_n_i), .mode_i(mode_i), .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
  .dout_rdy_o(dout_rdy_o), .dout_rdy_oe_o(dout_rdy_oe_o), .filter_word_i(filter_word_i));
`default_nettype wire

// *** test/sdasr_host_model.sv ***
// Purpose : host serial port that reads result words
// Assumes : slave clock levels last eight system clocks
// Notes   : in the master role it only listens
`timescale 1ns/1ps
`default_nettype none
module sdasr_host_model
(
  // clock and role
  input  wire logic clk_i,
  input  wire logic mode_i,
  // resolved pin levels
  input  wire logic sclk_line_i,
  input  wire logic dout_line_i,
  // host clock driver
  output var  logic sclk_drv_o,
  output      logic sclk_drv_oe_o
);
  import sdasr_pkg::*;
  // host owns the clock only as slave partner
  assign sclk_drv_oe_o = mode_i;
  initial sclk_drv_o = 1'b1;
  // fall then rise per bit; sample at the rise
  task automatic shift_in(input int n, inout logic [WORD_BITS-1:0] w);
    repeat (n)
    begin
      @(posedge clk_i);
      sclk_drv_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      w = {w[WORD_BITS-2:0], dout_line_i};
      sclk_drv_o <= 1'b1;
      repeat (7) @(posedge clk_i);
    end
  endtask : shift_in
  // listen to the device clock, bounded
  task automatic take_master(inout logic [WORD_BITS-1:0] w, output int n);
    logic prev;
    int   cyc;
    prev = sclk_line_i;
    n = 0;
    cyc = 0;
    while (n < WORD_BITS && cyc < 3000)
    begin
      @(posedge clk_i);
      if (sclk_line_i && !prev)
      begin
        w = {w[WORD_BITS-2:0], dout_line_i};
        n++;
      end
      prev = sclk_line_i;
      cyc++;
    end
  endtask : take_master
endmodule : sdasr_host_model
`default_nettype wire

// *** test/sdasr_readout_tb.sv ***
// Purpose : self-checking bench for the serial readout
// Assumes : short pll lock; crystal 160 ns
// Notes   : slave reads first, then master
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module sdasr_readout_tb;
  import sdasr_pkg::*;
  localparam int LOCK  = 4;
  localparam int PER   = (DECIM_CYCLES * 160) / 25;
  localparam int FIRST = ((LOCK + 2 + 2 * DECIM_CYCLES) * 160) / 25 + 4;
  localparam int LIMIT = 80000;
  logic clk_i, resetn_i, crystal_clock_i, cs_n_i, mode_i, sclk_i;
  logic sclk_o, sclk_oe_o, dout_rdy_o, dout_rdy_oe_o, host_sclk, host_oe;
  logic [WORD_BITS-1:0] filter_word_i, word;
  int num_errors, compares, cycles, t0, t1, n;
  // pull-ups hold both released lines high
  wire logic sclk_line = sclk_oe_o ? sclk_o : (host_oe ? host_sclk : 1'b1);
  wire logic dout_line = dout_rdy_oe_o ? dout_rdy_o : 1'b1;
  sdasr_readout #(.LOCK_CYCLES(LOCK)) dut (.clk_i(clk_i), .resetn_i(resetn_i), .crystal_clock_i(crystal_clock_i),
    .cs_n_i(cs_n_i), .mode_i(mode_i), .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
    .dout_rdy_o(dout_rdy_o), .dout_rdy_oe_o(dout_rdy_oe_o), .filter_word_i(filter_word_i));
  sdasr_host_model host (.clk_i(clk_i), .mode_i(mode_i), .sclk_line_i(sclk_line), .dout_line_i(dout_line),
    .sclk_drv_o(host_sclk), .sclk_drv_oe_o(host_oe));
  initial begin clk_i = 1'b0; forever #12.5 clk_i = ~clk_i; end
  // crystal phase unrelated to clk_i
  initial begin crystal_clock_i = 1'b0; #37; forever #80 crystal_clock_i = ~crystal_clock_i; end
  always @(posedge clk_i) sclk_i <= sclk_line;
  // counted off the falling clk_i edge; runaway cut
  always @(negedge clk_i)
  begin
    cycles++;
    if (cycles == LIMIT) begin num_errors++; report_and_stop(); end
  end
  function automatic logic near(input int got, input int exp, input int tol);
    return (got >= exp - tol) && (got <= exp + tol);
  endfunction : near
  task automatic wait_dout(input logic lvl, input int max);
    int k;
    k = 0;
    while (dout_line !== lvl && k < max) begin @(posedge clk_i); k++; end
    `CHK(dout_line, lvl)
  endtask : wait_dout
  task automatic t_slave;
    @(posedge clk_i);
    mode_i <= 1'b1;
    cs_n_i <= 1'b0;
    filter_word_i <= 24'h12_3456;
    t0 = cycles;
    repeat (8) @(posedge clk_i);
    `CHK(dout_rdy_oe_o, 1'b1)
    `CHK(dout_line, 1'b1)
    wait_dout(1'b0, FIRST + 40);
    t1 = cycles;
    `CHK(near(t1 - t0, FIRST, 16), 1'b1)
    word = 24'h00_0000;
    host.shift_in(8, word);
    filter_word_i <= 24'h7F_FFFF;
    host.shift_in(16, word);
    `CHK(word, 24'h12_3456 ^ 24'h80_0000)
    repeat (6) @(posedge clk_i);
    `CHK(dout_line, 1'b1)
    wait_dout(1'b0, PER);
    `CHK(near(cycles - t1, PER, 4), 1'b1)
    t1 = cycles;
    wait_dout(1'b1, PER); // left unread
    `CHK(near(cycles - t1, PER - (WARN_MARGIN * 160) / 25, 4), 1'b1)
    wait_dout(1'b0, 100);
    `CHK(near(cycles - t1, PER, 4), 1'b1)
    cs_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK({dout_rdy_oe_o, sclk_oe_o, dout_line}, 3'h1)
  endtask : t_slave
  task automatic t_master;
    @(posedge clk_i);
    mode_i <= 1'b0;
    cs_n_i <= 1'b0;
    filter_word_i <= 24'h80_5A3C;
    t0 = cycles;
    repeat (8) @(posedge clk_i);
    `CHK(sclk_oe_o, 1'b1)
    wait_dout(1'b0, FIRST + 40);
    `CHK(near(cycles - t0, FIRST, 16), 1'b1)
    word = 24'hFF_FFFF;
    host.take_master(word, n);
    `CHK(n == WORD_BITS, 1'b1)
    `CHK(word, 24'h80_5A3C ^ 24'h80_0000)
    repeat (6) @(posedge clk_i);
    repeat (8) begin @(posedge clk_i); `CHK({sclk_line, dout_line}, 2'h3) end
  endtask : t_master
  task automatic report_and_stop;
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    num_errors = 0;
    compares = 0;
    cycles = 0;
    resetn_i = 1'b0;
    cs_n_i = 1'b1;
    mode_i = 1'b1;
    sclk_i = 1'b1;
    filter_word_i = 24'h00_0000;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_slave();
    t_master();
    report_and_stop();
  end
endmodule : sdasr_readout_tb
`undef CHK
`default_nettype wire
